// ### see_pkg.sv
// Shared constants and carrier types for the serial EEPROM slave front end.
package see_pkg;

  // Select byte layout, most significant bit first on the wire.
  localparam int unsigned SEL_TYPE_MSB  = 7;
  localparam int unsigned SEL_TYPE_LSB  = 4;
  localparam int unsigned SEL_STRAP_BIT = 3;
  localparam int unsigned SEL_A17_BIT   = 2;
  localparam int unsigned SEL_A16_BIT   = 1;
  localparam int unsigned SEL_RW_BIT    = 0;
  localparam logic [3:0]  DEV_TYPE_MEM  = 4'ha;
  localparam logic        RW_READ       = 1'h1;

  // Bit counter positions within one nine-bit slot.
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  BIT_FIRST     = 4'h0;

  // The pad only ever pulls low.
  localparam logic        SDA_PULL_LVL  = 1'h0;

  // Internal write cycle length.
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned T_WRITE_US    = 5000;
  localparam int unsigned WRITE_CYCLES  = T_WRITE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W       = 20;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_ACTIVE,
    ST_WRITE
  } see_mode_e;

  typedef enum logic [2:0] {
    PH_SELECT,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA,
    PH_READ,
    PH_IGNORE
  } see_phase_e;

  // Address and data of the byte handed to the array at a write commit.
  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  data;
  } see_wr_word_s;

endpackage

// ### see_front_end.sv
// Serial EEPROM slave front end: select match, write protect, ack drive, power-on gating.
`timescale 1ns/1ps
`default_nettype none

module see_front_end #(
  parameter int unsigned WRITE_CYCLES = see_pkg::WRITE_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  scl_clk,
  input  wire logic                  sda_i,
  output var  logic                  sda_o,
  output var  logic                  sda_oe,
  input  wire logic                  chip_select_strap,
  input  wire logic                  write_protect_input,
  output var  logic                  standby,
  output var  logic                  write_busy,
  output var  logic                  write_commit,
  output var  see_pkg::see_wr_word_s write_word
);

  // State of the reference clock side: pin sampling, mode and write timer.
  typedef struct packed {
    logic                   scl_p;
    logic                   sda_p;
    see_pkg::see_mode_e     mode;
    logic                   clear;
    logic                   link_rst_n;
    logic [see_pkg::TIMER_W-1:0] timer;
    logic                   standby;
    logic                   busy;
    logic                   commit;
    see_pkg::see_wr_word_s  word;
  } see_ref_s;

  // State clocked by the rising edge of the bus clock.
  typedef struct packed {
    logic [3:0]             cnt;
    logic [7:0]             shreg;
    see_pkg::see_phase_e    phase;
    logic                   ack_due;
    logic                   data_byte;
    logic                   data_acked;
    logic                   deselect;
    logic [17:0]            addr;
    logic [7:0]             data;
  } see_rise_s;

  // State clocked by the falling edge of the bus clock.
  typedef struct packed {
    logic                   pull;
    logic                   oe;
  } see_fall_s;

  see_ref_s  ref_reg;
  see_ref_s  ref_next;
  see_rise_s rise_reg;
  see_rise_s rise_next;
  see_fall_s fall_reg;
  see_fall_s fall_next;

  logic      start_seen;
  logic      stop_seen;
  logic [7:0] byte_in;
  logic      sel_match;
  logic      scl_s;
  logic      sda_s;
  logic      ack_s;
  logic      des_s;
  logic      wp_s;
  logic      strap_s;

  // ---------------------------------------------------------------------------
  // Reference clock side.
  // ---------------------------------------------------------------------------

  // The bus pins rest high, so their synchronisers reset high and no false edge
  // follows a power-on reset.
  see_sync2 #(
    .WIDTH     (2),
    .RESET_LVL (1'b1)
  ) pin_sync_inst (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     ({scl_clk, sda_i}),
    .q     ({scl_s, sda_s})
  );

  // Flags from the bus clock side. The ack flag stands for at least a whole bit time and
  // deselect holds until the bit logic is reset, so plain two-stage resampling is enough and no handshake is needed.
  see_sync2 #(
    .WIDTH     (2),
    .RESET_LVL (1'b0)
  ) flag_sync_inst (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     ({rise_reg.data_acked, rise_reg.deselect}),
    .q     ({ack_s, des_s})
  );

  // Start and stop are only judged from synchronised, settled samples.
  assign start_seen = scl_s & ref_reg.scl_p & ref_reg.sda_p & ~sda_s;
  assign stop_seen  = scl_s & ref_reg.scl_p & ~ref_reg.sda_p & sda_s;

  always_comb begin
    ref_next        = ref_reg;
    ref_next.scl_p  = scl_s;
    ref_next.sda_p  = sda_s;
    ref_next.commit = 1'b0;
    // The bit logic stays cleared from a start until the bus clock is low, so its
    // reset is released while no rising edge can be near.
    if (ref_reg.clear && !scl_s) begin
      ref_next.clear = 1'b0;
    end
    case (ref_reg.mode)
      see_pkg::ST_STANDBY: begin
        if (start_seen) begin
          ref_next.mode  = see_pkg::ST_ACTIVE;
          ref_next.clear = 1'b1;
        end
      end
      see_pkg::ST_ACTIVE: begin
        if (start_seen) begin
          ref_next.clear = 1'b1;
        end else if (stop_seen) begin
          if (ack_s) begin
            // The bus clock sits high before a stop, so the captured address and
            // data have been stable for many cycles when they are copied here.
            ref_next.mode      = see_pkg::ST_WRITE;
            ref_next.timer     = see_pkg::TIMER_W'(WRITE_CYCLES - 1);
            ref_next.commit    = 1'b1;
            ref_next.word.addr = rise_reg.addr;
            ref_next.word.data = rise_reg.data;
          end else begin
            ref_next.mode = see_pkg::ST_STANDBY;
          end
        end else if (des_s) begin
          ref_next.mode = see_pkg::ST_STANDBY;
        end
      end
      see_pkg::ST_WRITE: begin
        // Starts are not looked at until the write cycle ends.
        if (ref_reg.timer == '0) begin
          ref_next.mode = see_pkg::ST_STANDBY;
        end else begin
          ref_next.timer = ref_reg.timer - 1'b1;
        end
      end
      default: begin
        ref_next.mode = see_pkg::ST_STANDBY;
      end
    endcase
    // The bit logic only runs inside an accepted frame.
    ref_next.link_rst_n = (ref_next.mode == see_pkg::ST_ACTIVE) && !ref_next.clear;
    ref_next.standby    = (ref_next.mode == see_pkg::ST_STANDBY);
    ref_next.busy       = (ref_next.mode == see_pkg::ST_WRITE);
  end

  // Power-on reset holds everything; its release lands in Standby.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // The previous pin samples rest at the idle high level of the bus.
      ref_reg         <= '0;
      ref_reg.scl_p   <= 1'b1;
      ref_reg.sda_p   <= 1'b1;
      ref_reg.standby <= 1'b1;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus clock side. Its reset comes from a flip-flop of the reference side, which
  // also drops at once when the power-on reset is asserted again.
  // ---------------------------------------------------------------------------

  assign byte_in   = {rise_reg.shreg[6:0], sda_i};
  // An open strap pin is pulled to logic zero at the pad.
  assign sel_match =
    (byte_in[see_pkg::SEL_TYPE_MSB:see_pkg::SEL_TYPE_LSB] == see_pkg::DEV_TYPE_MEM) &&
    (byte_in[see_pkg::SEL_STRAP_BIT] == strap_s);

  // Strap and protect levels, resampled on the bus clock and cleared at each start.
  // They settle within the first two select bits, long before either is used.
  see_sync2 #(
    .WIDTH     (2),
    .RESET_LVL (1'b0)
  ) strap_sync_inst (
    .clk   (scl_clk),
    .rst_n (ref_reg.link_rst_n),
    .d     ({write_protect_input, chip_select_strap}),
    .q     ({wp_s, strap_s})
  );

  always_comb begin
    rise_next         = rise_reg;
    if (rise_reg.cnt == see_pkg::BIT_ACK) begin
      rise_next.cnt        = see_pkg::BIT_FIRST;
      rise_next.data_acked = rise_reg.ack_due && rise_reg.data_byte;
      rise_next.ack_due    = 1'b0;
      rise_next.data_byte  = 1'b0;
    end else begin
      rise_next.shreg      = byte_in;
      rise_next.cnt        = rise_reg.cnt + 1'b1;
      // A stop needs one more clock pulse after the acknowledge, so the flag is kept
      // through that pulse and only dropped by the one after it.
      rise_next.data_acked = rise_reg.data_acked && (rise_reg.cnt == see_pkg::BIT_FIRST);
      if (rise_reg.cnt == see_pkg::BIT_LAST) begin
        case (rise_reg.phase)
          see_pkg::PH_SELECT: begin
            if (sel_match) begin
              rise_next.ack_due = 1'b1;
              rise_next.addr[17] = byte_in[see_pkg::SEL_A17_BIT];
              rise_next.addr[16] = byte_in[see_pkg::SEL_A16_BIT];
              if (byte_in[see_pkg::SEL_RW_BIT] == see_pkg::RW_READ) begin
                rise_next.phase = see_pkg::PH_READ;
              end else begin
                rise_next.phase = see_pkg::PH_ADDR_HI;
              end
            end else begin
              rise_next.phase    = see_pkg::PH_IGNORE;
              rise_next.deselect = 1'b1;
            end
          end
          see_pkg::PH_ADDR_HI: begin
            rise_next.ack_due    = 1'b1;
            rise_next.addr[15:8] = byte_in;
            rise_next.phase      = see_pkg::PH_ADDR_LO;
          end
          see_pkg::PH_ADDR_LO: begin
            rise_next.ack_due   = 1'b1;
            rise_next.addr[7:0] = byte_in;
            rise_next.phase     = see_pkg::PH_DATA;
          end
          see_pkg::PH_DATA: begin
            rise_next.data_byte = 1'b1;
            rise_next.ack_due   = !wp_s;
            if (!wp_s) begin
              rise_next.data = byte_in;
            end
          end
          default: begin
            // Read data and deselected frames leave the line to others.
            rise_next.ack_due = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl_clk or negedge ref_reg.link_rst_n) begin
    if (!ref_reg.link_rst_n) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  // The acknowledge goes out after the falling edge that ends the eighth bit and
  // stays through the ninth high phase, so it never moves while the clock is high.
  always_comb begin
    fall_next      = fall_reg;
    fall_next.pull = see_pkg::SDA_PULL_LVL;
    fall_next.oe   = (rise_reg.cnt == see_pkg::BIT_ACK) && rise_reg.ack_due;
  end

  always_ff @(negedge scl_clk or negedge ref_reg.link_rst_n) begin
    if (!ref_reg.link_rst_n) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign sda_o        = fall_reg.pull;
  assign sda_oe       = fall_reg.oe;
  assign standby      = ref_reg.standby;
  assign write_busy   = ref_reg.busy;
  assign write_commit = ref_reg.commit;
  assign write_word   = ref_reg.word;

endmodule // see_front_end

// Two flip-flop synchroniser for levels that cross into another clock domain.
module see_sync2 #(
  parameter int unsigned WIDTH     = 1,
  parameter logic        RESET_LVL = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // Both stages of every bit.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } see_sync_s;

  see_sync_s sync_reg;
  see_sync_s sync_next;

  // Only the second stage is read outside, so a metastable first stage has a full
  // clock to settle. A level taken in at one destination edge is seen after the next.
  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = d;
    sync_next.held = sync_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= {(2 * WIDTH){RESET_LVL}};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.held;

endmodule // see_sync2

`default_nettype wire

// ### see_front_end_properties.sv
// Port checks for the serial EEPROM slave front end.
`timescale 1ns/1ps
`default_nettype none
module see_front_end_properties #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire logic                  scl_clk,
  input wire logic                  sda_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe,
  input wire logic                  chip_select_strap,
  input wire logic                  write_protect_input,
  input wire logic                  standby,
  input wire logic                  write_busy,
  input wire logic                  write_commit,
  input wire see_pkg::see_wr_word_s write_word
);
  logic [19:0] busy_cnt_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) busy_cnt_reg <= '0;
    else busy_cnt_reg <= write_busy ? busy_cnt_reg + 20'h1 : '0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_busy_run; write_busy [*8]; endsequence
  sequence s_quiet; !sda_oe && standby && !write_busy && !write_commit; endsequence
  a_open_drain: assert property (sda_o == see_pkg::SDA_PULL_LVL)
    else $error("sda driven high");
  a_reset_standby: assert property ($rose(reset_n) |-> s_quiet)
    else $error("not idle after reset");
  a_commit_pulse: assert property (write_commit |=> !write_commit ##0 s_busy_run)
    else $error("commit without write cycle");
  a_busy_quiet: assert property (write_busy |-> !sda_oe && !standby)
    else $error("active during write cycle");
  a_busy_length: assert property ($fell(write_busy) |-> (busy_cnt_reg >= WRITE_CYCLES - 1
    && busy_cnt_reg <= WRITE_CYCLES + 1) ##[0:3] standby)
    else $error("write cycle length wrong");
  a_protect_commit: assert property (write_protect_input |-> !write_commit)
    else $error("commit while protected");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("ack moved with scl high");
  a_standby_release: assert property (standby |-> !sda_oe)
    else $error("standby drives sda");
endmodule // see_front_end_properties
`default_nettype wire

// ### see_i2c_master.sv
// Behavioural two-wire bus master that clocks SCL only inside frames.
`timescale 1ns/1ps
`default_nettype none
module see_i2c_master #(
  parameter int T = 512
) (
  output var logic scl_clk,
  output var logic sda_low,
  input  wire logic sda
);
  initial begin
    scl_clk = 1'h1;
    sda_low = 1'h0;
  end
  task automatic start();
    sda_low = 1'h1;
    #T scl_clk = 1'h0;
  endtask
  // Data only moves while SCL is low, and the released line floats to its pull-up.
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_low = (i >= 0) ? ~b[i] : 1'h0;
      #(T / 2) scl_clk = 1'h1;
      ack = ~sda;
      #T scl_clk = 1'h0;
      #(T / 2);
    end
  endtask
  task automatic stop();
    sda_low = 1'h1;
    #(T / 2) scl_clk = 1'h1;
    #T sda_low = 1'h0;
    #T;
  endtask
endmodule // see_i2c_master
`default_nettype wire

// ### see_front_end_test.sv
// Self-checking bench for the serial EEPROM slave front end.
`timescale 1ns/1ps
`default_nettype none
module see_front_end_test;
  localparam int unsigned WCYC = 400;
  localparam logic [10:0] TBL [7] = '{11'h0a2, 11'h1a4, 11'h4a0, 11'h4ae, 11'h6a8, 11'h0a1, 11'h0b0};
  logic                  ref_clk = 1'h0;
  logic                  reset_n = 1'h0;
  logic                  strap = 1'h0;
  logic                  wp = 1'h0;
  logic                  ack, scl, m_low, sda_oe, sda_o, standby, busy, commit;
  see_pkg::see_wr_word_s word;
  logic [31:0]           rng = 32'hf631;
  logic [25:0]           exp_q [$];
  int                    fails = 0;
  int                    samples_checked = 0;
  wire logic             sda = ~(m_low | (sda_oe & ~sda_o));
  see_i2c_master see_i2c_master_inst (.scl_clk(scl), .sda_low(m_low), .sda(sda));
  see_front_end #(.WRITE_CYCLES(WCYC)) see_front_end_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .chip_select_strap(strap), .write_protect_input(wp), .standby(standby),
    .write_busy(busy), .write_commit(commit), .write_word(word));
  initial forever #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic complete_run();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [25:0] got, input logic [25:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_standby();
    int n;
    for (n = 0; n < 2000 && standby !== 1'h1; n++) @(posedge ref_clk);
    if (n == 2000) begin
      fails++;
      complete_run();
    end
  endtask
  // An ignored frame starts straight away so that it lands inside the write cycle.
  task automatic xfer(input logic s, input logic w, input logic ign, input logic [7:0] sel);
    logic m, wr;
    logic [23:0] adr_dat;
    if (!ign) wait_standby();
    rng = xs(rng);
    adr_dat = rng[23:0];
    @(posedge ref_clk);
    strap <= s;
    wp <= w;
    m = sel[7:4] == see_pkg::DEV_TYPE_MEM && sel[3] == s && !ign;
    wr = m && sel[0] != see_pkg::RW_READ;
    see_i2c_master_inst.start();
    see_i2c_master_inst.send(sel, ack);
    check_bit(ack, m);
    for (int i = 2; i >= 0; i--) begin
      see_i2c_master_inst.send(adr_dat[i*8+:8], ack);
      check_bit(ack, wr && (i > 0 || !w));
    end
    if (wr && !w) exp_q.push_back({sel[2:1], adr_dat});
    see_i2c_master_inst.stop();
  endtask
  always @(negedge ref_clk) begin
    if (commit === 1'h1) check_word(word, exp_q.size() != 0 ? exp_q.pop_front() : ~word);
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    foreach (TBL[i]) xfer(TBL[i][10], TBL[i][9], TBL[i][8], TBL[i][7:0]);
    repeat (4) begin
      rng = xs(rng);
      xfer(rng[4], rng[5], 1'h0, {4'ha, rng[3:0]});
    end
    wait_standby();
    see_i2c_master_inst.start();
    see_i2c_master_inst.send(8'ha0, ack);
    @(posedge ref_clk);
    reset_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    check_bit(standby, 1'h1);
    see_i2c_master_inst.send(8'h12, ack);
    check_bit(ack, 1'h0);
    see_i2c_master_inst.stop();
    @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    xfer(1'h0, 1'h0, 1'h0, 8'ha6);
    wait_standby();
    check_bit(exp_q.size() == 0, 1'h1);
    complete_run();
  end
endmodule // see_front_end_test
bind see_front_end see_front_end_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .chip_select_strap(chip_select_strap),
  .write_protect_input(write_protect_input), .standby(standby), .write_busy(write_busy),
  .write_commit(write_commit), .write_word(write_word));
`default_nettype wire
